// *** shared/cdt_pkg.sv ***
// constants, types and decode helpers shared by the doze throttle block
package cdt_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;

   // control register fields
   localparam int CTRL_DOZE_EN_BIT = 0;
   localparam int CTRL_ROI_BIT     = 1;
   localparam int CTRL_DOE_BIT     = 2;
   localparam int CTRL_RATIO_LSB   = 4;
   localparam int RATIO_W          = 3;

   // status register fields
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_ISR_BIT    = 1;
   localparam int STAT_WAIT_BIT   = 2;
   localparam int STAT_DOZE_BIT   = 3;
   localparam int STAT_PHASE_LSB  = 4;

   // reset values
   localparam logic               DOZE_EN_RST = 1'b0;
   localparam logic               ROI_RST     = 1'b0;
   localparam logic               DOE_RST     = 1'b0;
   localparam logic [RATIO_W-1:0] RATIO_RST   = 3'h0;

   // quarter-phase clocks: four system clocks per instruction cycle
   localparam int         Q_PHASES = 4;
   localparam logic [3:0] Q_INIT   = 4'h1;

   localparam int          SKIP_CNT_W = 8;
   localparam logic [15:0] ISR_VECTOR = 16'h0004;

   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_WAIT = 3'b010,
      ST_ISR  = 3'b100
   } cdt_state_t;

   typedef struct packed {
      logic irq_pending;
      logic global_interrupt_enable;
      logic mc_busy;
      logic isr_return;
      logic prefetch_clears_gie;
   } cdt_irq_in_t;

   typedef struct packed {
      logic        exec_en;
      logic        fetch_en;
      logic [3:0]  cpu_q;
      logic        vector_fetch;
      logic [15:0] vector_addr;
   } cdt_cpu_out_t;

   // ratio code k gives 1 active cycle in 2^(k+1); returns N-1
   function automatic logic [SKIP_CNT_W-1:0] ratio_last(input logic [RATIO_W-1:0] code);
      logic [SKIP_CNT_W:0] n;
      n = 9'h002 << code;
      return n[SKIP_CNT_W-1:0] - 8'h01;
   endfunction

endpackage

// *** src/cdt_skip_counter.sv ***
// instruction cycle skip counter: one active cycle out of every N
`timescale 1ns/100ps
module cdt_skip_counter (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        cyc_en,
   input  wire logic                        hold,
   input  wire logic [cdt_pkg::RATIO_W-1:0] ratio,
   output logic                             active_ff
);
   import cdt_pkg::*;

   logic [SKIP_CNT_W-1:0] cnt_ff;
   logic [SKIP_CNT_W-1:0] nxt_cnt;
   logic [SKIP_CNT_W-1:0] last;

   // >= so that a ratio shrunk mid-period wraps at once instead of running to 255
   always_comb begin
      last = ratio_last(ratio);
      if (hold) begin
         nxt_cnt = '0;
      end else if (cnt_ff >= last) begin
         nxt_cnt = '0;
      end else begin
         nxt_cnt = cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff    <= '0;
         active_ff <= 1'b1;
      end else if (cyc_en) begin
         cnt_ff    <= nxt_cnt;
         active_ff <= (nxt_cnt == 8'h00);
      end
   end

endmodule

// *** src/cdt_doze_throttle.sv ***
// cpu doze throttle: instruction cycle gating, doze interrupt handling, control registers
`timescale 1ns/100ps
module cdt_doze_throttle (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [cdt_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [cdt_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [cdt_pkg::DATA_W-1:0] reg_rdata,
   input  wire cdt_pkg::cdt_irq_in_t       irq_in,
   output cdt_pkg::cdt_cpu_out_t           cpu_out,
   output logic      [3:0]                 periph_q,
   output logic                            osc_run,
   output logic                            doze_active
);
   import cdt_pkg::*;

   logic                 doze_en_ff;
   logic                 roi_ff;
   logic                 doe_ff;
   logic [RATIO_W-1:0]   ratio_ff;
   logic [3:0]           q_ff;
   logic                 cpu_active_ff;
   logic                 vec_ff;
   logic [DATA_W-1:0]    rdata_ff;
   cdt_state_t           state_ff;
   cdt_state_t           nxt_state;
   logic                 nxt_vec;
   logic                 hw_clr_doze;
   logic                 hw_set_doze;
   logic                 hw_doze_val;
   logic                 boundary;
   logic                 wr_ctrl;

   assign boundary = q_ff[3];
   assign wr_ctrl  = reg_wr && (reg_addr == CTRL_OFS);

   // quarter-phase ring never stops, whatever the cpu is doing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff <= Q_INIT;
      end else begin
         q_ff <= {q_ff[2:0], q_ff[3]};
      end
   end

   assign periph_q = q_ff;
   assign osc_run  = 1'b1;

   cdt_skip_counter u_skip (
      .clk       (clk),
      .rst_n     (rst_n),
      .cyc_en    (boundary),
      .hold      (!doze_en_ff),
      .ratio     (ratio_ff),
      .active_ff (cpu_active_ff)
   );

   // only the cpu and flash see the gated cycle; fetch and execute share it
   always_comb begin
      cpu_out.exec_en      = cpu_active_ff;
      cpu_out.fetch_en     = cpu_active_ff;
      cpu_out.cpu_q        = q_ff & {4{cpu_active_ff}};
      cpu_out.vector_fetch = vec_ff;
      cpu_out.vector_addr  = ISR_VECTOR;
   end

   assign doze_active = doze_en_ff;

   // interrupt sequencing; the recover and vector decisions in ST_WAIT are made at the first quarter of a cycle
   always_comb begin
      nxt_state   = state_ff;
      nxt_vec     = 1'b0;
      hw_clr_doze = 1'b0;
      hw_set_doze = 1'b0;
      hw_doze_val = 1'b0;
      case (state_ff)
         ST_RUN: begin
            if (irq_in.irq_pending) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!irq_in.irq_pending) begin
               nxt_state = ST_RUN;
            end else if (q_ff[0] && !irq_in.mc_busy) begin
               if (roi_ff && doze_en_ff) begin
                  hw_clr_doze = 1'b1;
               end else if (cpu_active_ff) begin
                  if (irq_in.global_interrupt_enable && !irq_in.prefetch_clears_gie) begin
                     nxt_vec   = 1'b1;
                     nxt_state = ST_ISR;
                  end else begin
                     nxt_state = ST_RUN;
                  end
               end
            end
         end
         ST_ISR: begin
            if (irq_in.isr_return) begin
               hw_set_doze = 1'b1;
               hw_doze_val = doe_ff;
               nxt_state   = ST_RUN;
            end
         end
         default: begin
            nxt_state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_RUN;
         vec_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         vec_ff   <= nxt_vec;
      end
   end

   // hardware updates of doze enable win over a software write in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         doze_en_ff <= DOZE_EN_RST;
      end else if (hw_clr_doze) begin
         doze_en_ff <= 1'b0;
      end else if (hw_set_doze) begin
         doze_en_ff <= hw_doze_val;
      end else if (wr_ctrl) begin
         doze_en_ff <= reg_wdata[CTRL_DOZE_EN_BIT];
      end
   end

   // doze-on-exit may be rewritten inside the service routine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         roi_ff   <= ROI_RST;
         doe_ff   <= DOE_RST;
         ratio_ff <= RATIO_RST;
      end else if (wr_ctrl) begin
         roi_ff   <= reg_wdata[CTRL_ROI_BIT];
         doe_ff   <= reg_wdata[CTRL_DOE_BIT];
         ratio_ff <= reg_wdata[CTRL_RATIO_LSB +: RATIO_W];
      end
   end

   // read data stand for one cycle only; unmapped offsets read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= '0;
         if (reg_rd && reg_addr == CTRL_OFS) begin
            rdata_ff[CTRL_DOZE_EN_BIT]              <= doze_en_ff;
            rdata_ff[CTRL_ROI_BIT]                  <= roi_ff;
            rdata_ff[CTRL_DOE_BIT]                  <= doe_ff;
            rdata_ff[CTRL_RATIO_LSB +: RATIO_W]     <= ratio_ff;
         end else if (reg_rd && reg_addr == STAT_OFS) begin
            rdata_ff[STAT_ACTIVE_BIT]               <= cpu_active_ff;
            rdata_ff[STAT_ISR_BIT]                  <= (state_ff == ST_ISR);
            rdata_ff[STAT_WAIT_BIT]                 <= (state_ff == ST_WAIT);
            rdata_ff[STAT_DOZE_BIT]                 <= doze_en_ff;
            rdata_ff[STAT_PHASE_LSB +: Q_PHASES]    <= q_ff;
         end
      end
   end

   assign reg_rdata = rdata_ff;

   // ---- checks ----
   logic [SKIP_CNT_W-1:0] idle_run_ff;
   logic                  fresh_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_run_ff <= '0;
      end else if (boundary) begin
         idle_run_ff <= cpu_active_ff ? 8'h00 : idle_run_ff + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fresh_ff <= 1'b0;
      end else if (boundary) begin
         fresh_ff <= 1'b0;
      end else if (doze_en_ff && !fresh_ff && $rose(doze_en_ff)) begin
         fresh_ff <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_full_speed_run: assert property (
      boundary && !doze_en_ff |=> cpu_active_ff [*4])
      else $error("cpu idle while doze is off");

   a_period_wraps: assert property (
      boundary && doze_en_ff && !cpu_active_ff
         && idle_run_ff == ratio_last(ratio_ff) - 8'h01 |=> cpu_active_ff)
      else $error("active cycle missing after N-1 idle cycles");

   a_ratio4_idle: assert property (
      boundary && doze_en_ff && ratio_ff == 3'h1 && !cpu_active_ff
         && idle_run_ff < 8'h02 |=> !cpu_active_ff)
      else $error("1:4 ratio ended idle period early");

   a_q_ring_turns: assert property (
      q_ff == 4'h1 |=> q_ff == 4'h2 ##1 q_ff == 4'h4 ##1 q_ff == 4'h8 ##1 q_ff == 4'h1)
      else $error("peripheral quarter clocks stalled");

   a_cpu_q_gated: assert property (
      !cpu_active_ff |-> cpu_out.cpu_q == 4'h0 && periph_q != 4'h0)
      else $error("idle cycle gating wrong");

   a_vector_after_mc: assert property (
      $rose(vec_ff) |-> !$past(irq_in.mc_busy) && $past(q_ff[0]) && cpu_active_ff)
      else $error("vector fetched during multicycle or idle cycle");

   a_roi_clears_doze: assert property (
      state_ff == ST_WAIT && irq_in.irq_pending && q_ff[0] && !irq_in.mc_busy
         && roi_ff && doze_en_ff |=> !doze_en_ff)
      else $error("recover-on-interrupt did not clear doze");

   a_gie_blocks_isr: assert property (
      nxt_vec |-> irq_in.global_interrupt_enable && !irq_in.prefetch_clears_gie)
      else $error("service taken with interrupts disabled");

   a_exit_doze_doe: assert property (
      state_ff == ST_ISR && irq_in.isr_return |=> doze_en_ff == $past(doe_ff)
         && state_ff == ST_RUN)
      else $error("doze state after service return wrong");

   a_restart_skip: assert property (
      boundary && fresh_ff && doze_en_ff |=> !cpu_active_ff)
      else $error("skip counter not restarted on doze enable");

   c_vector_in_doze: cover property (vec_ff && doze_en_ff);
   c_roi_recover: cover property (hw_clr_doze ##[1:40] vec_ff);
   c_no_isr_exit: cover property (state_ff == ST_WAIT && !doze_en_ff ##1 state_ff == ST_RUN);
   c_resume_doze: cover property (hw_set_doze && doe_ff);

endmodule

// *** verif/cdt_cpu_model.sv ***
// behavioural cpu core and interrupt source facing the doze throttle
`timescale 1ns/100ps
module cdt_cpu_model #(
   parameter int ISR_LEN = 24
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  irq_req,
   input  wire logic                  gie_set,
   input  wire logic                  pcg_set,
   input  wire logic [7:0]            mc_len,
   input  wire cdt_pkg::cdt_cpu_out_t cpu_out,
   output cdt_pkg::cdt_irq_in_t       irq_in,
   output int                         vec_cnt,
   output logic                       vec_in_busy
);
   import cdt_pkg::*;
   logic [7:0] busy_ff;
   logic       req_d_ff;
   logic       served_ff;
   int         isr_ff;

   // a multicycle instruction is already in flight when the request arrives
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 8'h00;
         req_d_ff <= 1'b0;
      end else begin
         req_d_ff <= irq_req;
         if (irq_req && !req_d_ff) begin
            busy_ff <= mc_len;
         end else if (busy_ff != 8'h00) begin
            busy_ff <= busy_ff - 8'h01;
         end
      end
   end

   // the service routine runs a fixed length, then returns
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         served_ff <= 1'b0;
         isr_ff <= 0;
         vec_cnt <= 0;
         vec_in_busy <= 1'b0;
      end else begin
         served_ff <= irq_req && (served_ff || cpu_out.vector_fetch);
         if (cpu_out.vector_fetch) begin
            isr_ff <= ISR_LEN;
            vec_cnt <= vec_cnt + 1;
         end else if (isr_ff != 0) begin
            isr_ff <= isr_ff - 1;
         end
         if (cpu_out.vector_fetch && irq_in.mc_busy) begin
            vec_in_busy <= 1'b1;
         end
      end
   end

   assign irq_in.irq_pending = irq_req && !served_ff;
   assign irq_in.global_interrupt_enable = gie_set;
   assign irq_in.mc_busy = (busy_ff != 8'h00);
   assign irq_in.isr_return = (isr_ff == 1);
   assign irq_in.prefetch_clears_gie = pcg_set;
endmodule

// *** verif/cdt_doze_throttle_test.sv ***
// self-checking bench for the cpu doze throttle
`timescale 1ns/100ps
module cdt_doze_throttle_test;
   import cdt_pkg::*;
   logic                clk = 1'b0;
   logic                rst_n = 1'b0;
   logic [ADDR_W-1:0]   reg_addr = '0;
   logic [DATA_W-1:0]   reg_wdata = '0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [DATA_W-1:0]   reg_rdata;
   cdt_irq_in_t         irq_in;
   cdt_cpu_out_t        cpu_out;
   logic [3:0]          periph_q;
   logic                osc_run;
   logic                doze_active;
   logic                irq_req = 1'b0;
   logic                gie_set = 1'b1;
   logic                pcg_set = 1'b0;
   logic [7:0]          mc_len = 8'h0A;
   int                  vec_cnt;
   logic                vec_in_busy;
   int                  failures = 0;
   int                  checks_done = 0;
   logic [31:0]         d;
   int                  n;

   always #2.5 clk = ~clk;

   cdt_doze_throttle uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_in(irq_in),
      .cpu_out(cpu_out), .periph_q(periph_q), .osc_run(osc_run), .doze_active(doze_active));
   cdt_cpu_model #(.ISR_LEN(24)) cpu (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
      .gie_set(gie_set), .pcg_set(pcg_set), .mc_len(mc_len), .cpu_out(cpu_out),
      .irq_in(irq_in), .vec_cnt(vec_cnt), .vec_in_busy(vec_in_busy));

   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask

   // next negedge at which the peripheral phase equals q
   task automatic sync(input logic [3:0] q);
      @(negedge clk);
      repeat (4) if (periph_q !== q) @(negedge clk);
   endtask

   function automatic logic [31:0] ctl(input logic en, input logic recover_on_interrupt, input logic doze_on_exit,
                                       input int k);
      logic [31:0] c;
      c = 32'h0;
      c[CTRL_DOZE_EN_BIT] = en;
      c[CTRL_ROI_BIT] = recover_on_interrupt;
      c[CTRL_DOE_BIT] = doze_on_exit;
      c[CTRL_RATIO_LSB +: RATIO_W] = k[RATIO_W-1:0];
      return c;
   endfunction

   // one interrupt during doze at 1:4; unless pcg blocks the vector, software sets doze_on_exit inside the routine
   task automatic irq_case(input logic recover_on_interrupt, input logic doze_on_exit, input logic pcg);
      int v0;
      int i;
      wr(CTRL_OFS, ctl(1'b1, recover_on_interrupt, 1'b0, 1));
      @(posedge clk);
      pcg_set <= pcg;
      v0 = vec_cnt;
      irq_req <= 1'b1;
      for (i = 0; i < 300 && vec_cnt == v0; i++) @(negedge clk);
      if (pcg) begin
         check("vector count", v0, vec_cnt);
         check("doze after skip", 32'h0, doze_active);
         sync(4'h1);
         sync(4'h1);
         check("exec full speed", 32'h1, cpu_out.exec_en);
         @(posedge clk);
         irq_req <= 1'b0;
      end else begin
         check("vector count", v0 + 1, vec_cnt);
         check("vector addr", 32'h4, cpu_out.vector_addr);
         check("vector in mc", 32'h0, vec_in_busy);
         check("doze in isr", !recover_on_interrupt, doze_active);
         @(posedge clk);
         irq_req <= 1'b0;
         wr(CTRL_OFS, ctl(!recover_on_interrupt, recover_on_interrupt, doze_on_exit, 1));
         for (i = 0; i < 100 && irq_in.isr_return !== 1'b1; i++) @(negedge clk);
         @(negedge clk);
         @(negedge clk);
         check("doze after isr", doze_on_exit, doze_active);
      end
      wr(CTRL_OFS, 32'h0);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(CTRL_OFS, d);
      check("ctrl reset", 32'h0, d);
      check("osc_run", 32'h1, osc_run);
      check("doze reset", 32'h0, doze_active);
      rd(8'hFC, d);
      check("unmapped read", 32'h0, d);
      @(negedge clk);
      check("rdata idle", 32'h0, reg_rdata);
      for (int k = 0; k < 8; k++) begin
         n = 2 << k;
         // doze off across a full boundary so each ratio starts from a restarted count
         wr(CTRL_OFS, 32'h0);
         sync(4'h1);
         sync(4'h1);
         wr(CTRL_OFS, ctl(1'b1, 1'b0, 1'b0, k));
         sync(4'h1);
         check("doze on", 32'h1, doze_active);
         for (int i = 0; i < 4 * n; i++) begin
            check("exec_en", i >= 4 * (n - 1), cpu_out.exec_en);
            check("fetch_en", i >= 4 * (n - 1), cpu_out.fetch_en);
            check("cpu_q", (i >= 4 * (n - 1)) ? (4'h1 << (i % 4)) : 4'h0, cpu_out.cpu_q);
            check("periph_q", 4'h1 << (i % 4), periph_q);
            check("osc_run", 32'h1, osc_run);
            @(negedge clk);
         end
         if (k == 1) begin
            rd(STAT_OFS, d);
            check("stat doze bit", 32'h1, d[STAT_DOZE_BIT]);
         end
      end
      wr(CTRL_OFS, 32'h0);
      sync(4'h1);
      sync(4'h1);
      check("exec doze off", 32'h1, cpu_out.exec_en);
      irq_case(1'b1, 1'b1, 1'b0);
      irq_case(1'b1, 1'b0, 1'b0);
      irq_case(1'b0, 1'b1, 1'b0);
      irq_case(1'b1, 1'b0, 1'b1);
      stop_test();
   end
endmodule
